// ### logic/wms_sequencer.sv
// wheel mode sequencer: mode decode, drive path select, store commands
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "wms_map.svh"
module wms_sequencer #(
    parameter int unsigned FRAME_CYCLES = `WMS_FRAME_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] speed_meas,
    input wire logic [31:0] speed_loop_volt,
    input wire logic nv_user_valid,
    input wire logic [31:0] nv_user_inertia,
    input wire logic [31:0] nv_boot_inertia,
    output wms_pkg::wms_drive_t drive,
    output wms_pkg::wms_nv_req_t nv_req,
    output logic fault_inhibit,
    output logic coast_gather,
    output logic frame_tick
);
    logic [7:0] mode_reg;
    logic [31:0] value_reg;
    logic [31:0] inertia_reg;
    logic [31:0] ramp_target_reg;
    logic [7:0] hold_reg;
    logic user_saved_reg;
    logic boot_locked_reg;
    logic load_pending_reg;
    logic [17:0] frame_cnt_reg;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] wr_val;
    logic [31:0] rd_mux;
    logic is_save_one;
    logic is_save_two;
    logic is_erase_one;
    logic hw_clear;
    logic coast_now;
    logic [31:0] quot;
    wms_pkg::wms_path_t path_next;
    wms_pkg::wms_drive_t drive_next;

    // zero wait state slave; an unmapped address answers with pslverr
    assign pready = 1'b1;
    assign addr_ok = (paddr == `WMS_OFF_MODE) || (paddr == `WMS_OFF_VALUE)
        || (paddr == `WMS_OFF_SPEED) || (paddr == `WMS_OFF_INERTIA)
        || (paddr == `WMS_OFF_RAMP) || (paddr == `WMS_OFF_STATUS)
        || (paddr == `WMS_OFF_LOCK);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;

    // byte lanes merged into the current value of the addressed register
    always_comb
    begin
        wr_val = rd_mux;
        for (int i = 0; i < 4; i++)
        begin
            if (pstrb[i])
            begin
                wr_val[i*8 +: 8] = pwdata[i*8 +: 8];
            end
        end
    end

    // read multiplexer
    always_comb
    begin
        rd_mux = 32'h00000000;
        case (paddr)
            `WMS_OFF_MODE: rd_mux = {24'h000000, mode_reg};
            `WMS_OFF_VALUE: rd_mux = value_reg;
            `WMS_OFF_SPEED: rd_mux = speed_meas;
            `WMS_OFF_INERTIA: rd_mux = inertia_reg;
            `WMS_OFF_RAMP: rd_mux = ramp_target_reg;
            `WMS_OFF_STATUS:
            begin
                rd_mux[`WMS_ST_HOLD_LSB +: 8] = hold_reg;
                rd_mux[`WMS_ST_USER_SAVED] = user_saved_reg;
                rd_mux[`WMS_ST_BOOT_LOCKED] = boot_locked_reg;
                rd_mux[`WMS_ST_FAULT_INH] = fault_inhibit;
                rd_mux[`WMS_ST_PATH_LSB +: 5] = drive.path;
            end
            `WMS_OFF_LOCK: rd_mux = {31'h00000000, boot_locked_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data captured in the setup cycle, held through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= rd_mux;
    end

    // 100 Hz control frame divider
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_cnt_reg <= 18'h00000;
            frame_tick <= 1'b0;
        end
        else if (frame_cnt_reg == 18'(FRAME_CYCLES - 1))
        begin
            frame_cnt_reg <= 18'h00000;
            frame_tick <= 1'b1;
        end
        else
        begin
            frame_cnt_reg <= frame_cnt_reg + 18'h00001;
            frame_tick <= 1'b0;
        end
    end

    // power-up hold, reloaded by every reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_reg <= `WMS_HOLD_RESET;
        else if (frame_tick && hold_reg != 8'h00)
            hold_reg <= hold_reg - 8'h01;
    end

    // inhibit flag from a flip-flop, kept in step with the hold count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_inhibit <= 1'b1;
        else if (frame_tick && hold_reg == 8'h01)
            fault_inhibit <= 1'b0;
    end

    // mode register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= `WMS_MODE_RESET;
        else if (wr_en && paddr == `WMS_OFF_MODE)
            mode_reg <= wr_val[7:0];
    end

    // store and erase requests act once, then the value drops to zero
    assign is_save_one = (mode_reg == `WMS_M_SAVE)
        && (value_reg == `WMS_VAL_ONE);
    assign is_save_two = (mode_reg == `WMS_M_SAVE)
        && (value_reg == `WMS_VAL_TWO);
    assign is_erase_one = (mode_reg == `WMS_M_ERASE)
        && (value_reg == `WMS_VAL_ONE);
    assign coast_now = (mode_reg == `WMS_M_COAST)
        && (value_reg == `WMS_VAL_ONE);
    assign hw_clear = is_save_one | is_save_two | is_erase_one
        | (coast_now && speed_meas == 32'h00000000);

    // gather flag registered so it lines up with the drive path it explains
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            coast_gather <= 1'b0;
        else
            coast_gather <= coast_now;
    end

    // command value; a host write in the clearing cycle is a new request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value_reg <= 32'h00000000;
        else if (wr_en && paddr == `WMS_OFF_VALUE)
            value_reg <= wr_val;
        else if (hw_clear)
            value_reg <= 32'h00000000;
    end

    // store pulses; a locked boot store swallows the request silently
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nv_req <= '0;
        else
        begin
            nv_req.save_user <= is_save_one;
            nv_req.save_boot <= is_save_two & ~boot_locked_reg;
            nv_req.erase_user <= is_erase_one;
        end
    end

    // boot store lock, write one to set, only reset clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            boot_locked_reg <= 1'b0;
        else if (wr_en && paddr == `WMS_OFF_LOCK && wr_val[0])
            boot_locked_reg <= 1'b1;
    end

    // user copy present flag; strap caught on the first edge after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            user_saved_reg <= 1'b0;
        else if (load_pending_reg)
            user_saved_reg <= nv_user_valid;
        else if (is_save_one)
            user_saved_reg <= 1'b1;
        else if (is_erase_one)
            user_saved_reg <= 1'b0;
    end

    // live inertia parameter; erase never touches it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load_pending_reg <= 1'b1;
            inertia_reg <= `WMS_INERTIA_RESET;
        end
        else if (load_pending_reg)
        begin
            load_pending_reg <= 1'b0;
            inertia_reg <= nv_user_valid ? nv_user_inertia
                : nv_boot_inertia;
        end
        else if (wr_en && paddr == `WMS_OFF_INERTIA)
            inertia_reg <= wr_val;
    end

    // value over inertia in q16.16; zero inertia yields zero, not a trap
    always_comb
    begin
        logic signed [47:0] num;
        logic signed [47:0] q;
        num = {value_reg, 16'h0000};
        q = 48'sh000000000000;
        if (inertia_reg != 32'h00000000)
            q = num / $signed({{16{inertia_reg[31]}}, inertia_reg});
        quot = q[31:0];
    end

    // ramp target follows speed unless ramping; torque ramps at quot
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ramp_target_reg <= 32'h00000000;
        else if (mode_reg == `WMS_M_RAMP && hold_reg == 8'h00)
        begin
            if (frame_tick)
                ramp_target_reg <= ramp_target_reg + value_reg;
        end
        else if (mode_reg == `WMS_M_TORQUE && hold_reg == 8'h00)
        begin
            if (frame_tick)
                ramp_target_reg <= ramp_target_reg + quot;
        end
        else
            ramp_target_reg <= speed_meas;
    end

    // path decode; hold, store, erase, coast and unknown modes are off
    always_comb
    begin
        drive_next = '0;
        path_next = wms_pkg::WMS_PATH_OFF;
        if (hold_reg == 8'h00)
        begin
            if (mode_reg == `WMS_M_DUTY)
                path_next = wms_pkg::WMS_PATH_DUTY;
            else if (mode_reg == `WMS_M_VOLT)
                path_next = wms_pkg::WMS_PATH_VOLT;
            else if (mode_reg == `WMS_M_SPEED || mode_reg == `WMS_M_RAMP
                || mode_reg == `WMS_M_MOMENTUM || mode_reg == `WMS_M_TORQUE)
                path_next = wms_pkg::WMS_PATH_SPEED;
            else if (mode_reg >= `WMS_M_HDUTY_LO
                && mode_reg <= `WMS_M_HDUTY_HI)
            begin
                path_next = wms_pkg::WMS_PATH_DUTY;
                drive_next.hall_force = 1'b1;
                drive_next.hall_code = 3'(mode_reg - `WMS_M_HDUTY_LO + 8'h01);
            end
            else if (mode_reg >= `WMS_M_HVOLT_LO
                && mode_reg <= `WMS_M_HVOLT_HI)
            begin
                path_next = wms_pkg::WMS_PATH_VOLT;
                drive_next.hall_force = 1'b1;
                drive_next.hall_code = 3'(mode_reg - `WMS_M_HVOLT_LO + 8'h01);
            end
            else if (mode_reg >= `WMS_M_PHASE_LO
                && mode_reg <= `WMS_M_PHASE_HI)
            begin
                path_next = wms_pkg::WMS_PATH_PHASE;
                drive_next.phase = 2'(mode_reg - `WMS_M_PHASE_LO);
            end
            else
                path_next = wms_pkg::WMS_PATH_OFF;
        end
        drive_next.path = path_next;
        // setpoints only carried on the path that uses them
        case (path_next)
            wms_pkg::WMS_PATH_DUTY: drive_next.duty = value_reg;
            wms_pkg::WMS_PATH_PHASE: drive_next.duty = value_reg;
            wms_pkg::WMS_PATH_VOLT: drive_next.volt_sp = value_reg;
            wms_pkg::WMS_PATH_SPEED:
            begin
                drive_next.volt_sp = speed_loop_volt;
                if (mode_reg == `WMS_M_MOMENTUM)
                    drive_next.speed_sp = quot;
                else if (mode_reg == `WMS_M_SPEED)
                    drive_next.speed_sp = value_reg;
                else
                    drive_next.speed_sp = ramp_target_reg;
            end
            default: drive_next.duty = 32'h00000000;
        endcase
    end

    // drive outputs registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drive <= '{path: wms_pkg::WMS_PATH_OFF, default: '0};
        else
            drive <= drive_next;
    end
endmodule
`default_nettype wire

// ### logic/wms_map.svh
// constants, register offsets and timing counts of the wheel mode sequencer
// Contract
// - hold nonzero forces motor off, faults inhibited
// - hold count decrements per 100 Hz frame
// - start or restart loads hold with 5
// - mode 0x00 turns drive off
// - mode 0x01 open-loop signed duty
// - mode 0x02 closed-loop signed voltage
// - mode 0x03 speed loop feeds voltage loop
// - modes 0x04-0x09 forced hall, duty path
// - modes 0x0A-0x0F forced hall, voltage path
// - outside ramp and torque modes target tracks speed
// - ramp mode adds value per frame
// - mode 0x11 speed setpoint momentum/inertia
// - mode 0x12 ramp rate torque/inertia
// - save 1.0 writes user store once
// - save 2.0 writes boot store once
// - locked boot store: silent no save
// - save and erase modes keep drive off
// - erase 1.0 erases user store once
// - erase leaves live parameters untouched
// - reset loads parameters from saved user copy
// - single-phase modes drive one phase only
// - coast mode gathers at 1.0, clears at zero
`ifndef WMS_MAP_SVH
`define WMS_MAP_SVH
// register byte offsets
`define WMS_OFF_MODE 12'h000
`define WMS_OFF_VALUE 12'h004
`define WMS_OFF_SPEED 12'h008
`define WMS_OFF_INERTIA 12'h00C
`define WMS_OFF_RAMP 12'h010
`define WMS_OFF_STATUS 12'h014
`define WMS_OFF_LOCK 12'h018
// status field positions
`define WMS_ST_HOLD_LSB 0
`define WMS_ST_USER_SAVED 8
`define WMS_ST_BOOT_LOCKED 9
`define WMS_ST_FAULT_INH 10
`define WMS_ST_PATH_LSB 16
// reset values
`define WMS_HOLD_RESET 8'h05
`define WMS_MODE_RESET 8'h00
`define WMS_INERTIA_RESET 32'h00010000
// command value figures in signed q16.16
`define WMS_VAL_ONE 32'h00010000
`define WMS_VAL_TWO 32'h00020000
// mode numbers
`define WMS_M_OFF 8'h00
`define WMS_M_DUTY 8'h01
`define WMS_M_VOLT 8'h02
`define WMS_M_SPEED 8'h03
`define WMS_M_HDUTY_LO 8'h04
`define WMS_M_HDUTY_HI 8'h09
`define WMS_M_HVOLT_LO 8'h0A
`define WMS_M_HVOLT_HI 8'h0F
`define WMS_M_RAMP 8'h10
`define WMS_M_MOMENTUM 8'h11
`define WMS_M_TORQUE 8'h12
`define WMS_M_SAVE 8'h16
`define WMS_M_ERASE 8'h17
`define WMS_M_PHASE_LO 8'h18
`define WMS_M_PHASE_HI 8'h1A
`define WMS_M_COAST 8'h36
// timing
`define WMS_CLK_HZ 25000000
`define WMS_FRAME_HZ 100
`define WMS_FRAME_CYCLES (`WMS_CLK_HZ / `WMS_FRAME_HZ)
`endif

// ### logic/wms_pkg.sv
// types shared by the wheel mode sequencer
package wms_pkg;
    // drive path selection, one-hot
    typedef enum logic [4:0] {
        WMS_PATH_OFF = 5'h01,
        WMS_PATH_DUTY = 5'h02,
        WMS_PATH_VOLT = 5'h04,
        WMS_PATH_SPEED = 5'h08,
        WMS_PATH_PHASE = 5'h10
    } wms_path_t;

    // everything handed to the motor drive stage
    typedef struct packed {
        wms_path_t path;
        logic [31:0] duty;
        logic [31:0] volt_sp;
        logic [31:0] speed_sp;
        logic hall_force;
        logic [2:0] hall_code;
        logic [1:0] phase;
    } wms_drive_t;

    // nonvolatile store requests, one-cycle pulses
    typedef struct packed {
        logic save_user;
        logic save_boot;
        logic erase_user;
    } wms_nv_req_t;
endpackage

// ### bench/wms_seq_checker_assertions.sv
// port checker of the wheel mode sequencer
`timescale 1ns/100ps
`default_nettype none
module wms_seq_checker #(
    parameter int unsigned FRAME_CYCLES = 20
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire wms_pkg::wms_drive_t drive,
    input wire wms_pkg::wms_nv_req_t nv_req,
    input wire logic fault_inhibit,
    input wire logic coast_gather,
    input wire logic frame_tick
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] gap_reg;
    logic seen_reg;
    // cycles since the last tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_reg <= 32'h0;
        else
            gap_reg <= frame_tick ? 32'h0 : gap_reg + 32'h1;
    end
    // the first gap after reset has no known start, so it is not judged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_reg <= 1'b0;
        else if (frame_tick)
            seen_reg <= 1'b1;
    end
    property p_hold_off;
        fault_inhibit |-> drive.path == wms_pkg::WMS_PATH_OFF;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("drive active in hold");
    property p_hold_step;
        $fell(fault_inhibit) |-> $past(frame_tick);
    endproperty
    a_hold_step: assert property (p_hold_step)
        else $error("hold ended off a tick");
    property p_tick_gap;
        frame_tick && seen_reg |-> gap_reg == FRAME_CYCLES - 1;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("frame gap wrong");
    property p_req_pulse;
        |nv_req |=> nv_req == 3'h0;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("store request repeated");
    property p_store_idle;
        |nv_req |-> drive.path == wms_pkg::WMS_PATH_OFF;
    endproperty
    a_store_idle: assert property (p_store_idle)
        else $error("drive active in store");
    property p_off_quiet;
        drive.path == wms_pkg::WMS_PATH_OFF |->
            drive.duty == 32'h0 && drive.volt_sp == 32'h0;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("off path not quiet");
    property p_hall_code;
        drive.hall_force |-> drive.hall_code inside {[3'h1:3'h6]};
    endproperty
    a_hall_code: assert property (p_hall_code)
        else $error("forced code out of range");
    property p_coast_off;
        coast_gather |-> drive.path == wms_pkg::WMS_PATH_OFF;
    endproperty
    a_coast_off: assert property (p_coast_off)
        else $error("drive active in coast");
    c_save: cover property (nv_req.save_user);
    c_release: cover property ($fell(fault_inhibit));
    c_hall: cover property (drive.hall_force);
endmodule
bind wms_sequencer wms_seq_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .drive(drive), .nv_req(nv_req),
    .fault_inhibit(fault_inhibit), .coast_gather(coast_gather),
    .frame_tick(frame_tick)
);
`default_nettype wire

// ### bench/wms_store_model.sv
// nonvolatile stores and speed sensor facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module wms_store_model #(
    parameter logic [31:0] BOOT_INERTIA = 32'h00020000,
    parameter logic [31:0] SPEED = 32'h00030000
)(
    input wire logic pclk,
    input wire wms_pkg::wms_nv_req_t nv_req,
    input wire logic [31:0] live_inertia,
    output logic [31:0] speed_meas,
    output logic [31:0] speed_loop_volt,
    output var logic nv_user_valid,
    output var logic [31:0] nv_user_inertia,
    output logic [31:0] nv_boot_inertia
);
    // store contents outlive a device reset, so no reset here
    initial nv_user_valid = 1'b0;
    initial nv_user_inertia = 32'h0;
    always @(posedge pclk)
    begin
        if (nv_req.save_user === 1'b1)
            nv_user_inertia <= live_inertia;
        if (nv_req.save_user === 1'b1)
            nv_user_valid <= 1'b1;
        else if (nv_req.erase_user === 1'b1)
            nv_user_valid <= 1'b0;
    end
    // steady sensor readings
    assign speed_meas = SPEED;
    assign speed_loop_volt = 32'h00011000;
    assign nv_boot_inertia = BOOT_INERTIA;
endmodule
`default_nettype wire

// ### bench/wheel_mode_sequencer_test.sv
// self-checking bench of the wheel mode sequencer
`timescale 1ns/100ps
`default_nettype none
`include "wms_map.svh"
module wheel_mode_sequencer_test;
    localparam int unsigned FRAMES = 20;
    localparam logic [31:0] HALF = 32'h00008000;
    localparam logic [31:0] SPEED = 32'h00030000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic nv_user_valid, fault_inhibit, coast_gather, frame_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, live_inertia, speed_meas, slv;
    logic [31:0] nv_user_inertia, nv_boot_inertia;
    wms_pkg::wms_drive_t drive;
    wms_pkg::wms_nv_req_t nv_req;
    int miscompares, compares, n_user, n_boot, n_erase;
    logic [7:0] m_tab [16] = '{8'h00, 8'h02, 8'h04, 8'h09, 8'h0A, 8'h0F,
        8'h11, 8'h18, 8'h1A, 8'h16, 8'h34, 8'h20, 8'h03, 8'h12, 8'h19, 8'h35};
    logic [2:0] s_tab [16] = '{3'h0, 3'h0, 3'h1, 3'h6, 3'h1, 3'h6, 3'h0,
        3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0};
    wms_pkg::wms_path_t p_tab [16] = '{wms_pkg::WMS_PATH_OFF,
        wms_pkg::WMS_PATH_VOLT, wms_pkg::WMS_PATH_DUTY, wms_pkg::WMS_PATH_DUTY,
        wms_pkg::WMS_PATH_VOLT, wms_pkg::WMS_PATH_VOLT, wms_pkg::WMS_PATH_SPEED,
        wms_pkg::WMS_PATH_PHASE, wms_pkg::WMS_PATH_PHASE, wms_pkg::WMS_PATH_OFF,
        wms_pkg::WMS_PATH_OFF, wms_pkg::WMS_PATH_OFF,
        wms_pkg::WMS_PATH_SPEED, wms_pkg::WMS_PATH_SPEED,
        wms_pkg::WMS_PATH_PHASE, wms_pkg::WMS_PATH_OFF};

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    wms_sequencer #(.FRAME_CYCLES(FRAMES)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speed_meas(speed_meas),
        .speed_loop_volt(slv), .nv_user_valid(nv_user_valid),
        .nv_user_inertia(nv_user_inertia), .nv_boot_inertia(nv_boot_inertia),
        .drive(drive), .nv_req(nv_req), .fault_inhibit(fault_inhibit),
        .coast_gather(coast_gather), .frame_tick(frame_tick));
    wms_store_model #(.SPEED(SPEED)) nv (.pclk(pclk), .nv_req(nv_req),
        .live_inertia(live_inertia), .speed_meas(speed_meas),
        .speed_loop_volt(slv), .nv_user_valid(nv_user_valid),
        .nv_user_inertia(nv_user_inertia), .nv_boot_inertia(nv_boot_inertia));

    // count store pulses as the design issues them
    always @(posedge pclk)
    begin
        n_user += int'(nv_req.save_user === 1'b1);
        n_boot += int'(nv_req.save_boot === 1'b1);
        n_erase += int'(nv_req.erase_user === 1'b1);
    end

    task test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    task fail_wait;
        miscompares++;
        test_done;
    endtask

    // one transfer; the request stands until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            fail_wait;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // returns on the edge where a frame tick is taken
    task tick;
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (frame_tick !== 1'b1 && n < 4 * FRAMES);
        if (frame_tick !== 1'b1)
            fail_wait;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // a host keeps reading the value until the device clears it
    task req(input logic [31:0] v);
        int n;
        apb(1'b1, `WMS_OFF_VALUE, v);
        n = 0;
        do
        begin
            apb(1'b0, `WMS_OFF_VALUE, 32'h0);
            n++;
        end
        while (rd !== 32'h0 && n < 8);
        chk("value", 32'h0, rd);
    endtask

    task do_reset;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        live_inertia = 32'h00030000;
        do_reset;
        apb(1'b1, `WMS_OFF_VALUE, HALF);
        apb(1'b1, `WMS_OFF_MODE, 32'h1);
        apb(1'b0, `WMS_OFF_STATUS, 32'h0);
        chk("hold", 32'h5, {24'h0, rd[7:0]});
        repeat (4) tick;
        #1;
        chk("inhibit", 32'h1, {31'h0, fault_inhibit});
        chk("path", 32'(wms_pkg::WMS_PATH_OFF), 32'(drive.path));
        tick;
        #1;
        chk("inhibit", 32'h0, {31'h0, fault_inhibit});
        cyc(2);
        chk("duty", HALF, drive.duty);
        $display("test hold finished");
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, `WMS_OFF_MODE, {24'h0, m_tab[i]});
            cyc(2);
            chk("path", 32'(p_tab[i]), 32'(drive.path));
            if (p_tab[i] == wms_pkg::WMS_PATH_VOLT)
                chk("volt", HALF, drive.volt_sp);
            if (p_tab[i] == wms_pkg::WMS_PATH_DUTY)
                chk("duty", HALF, drive.duty);
            if (s_tab[i] != 3'h0 && p_tab[i] != wms_pkg::WMS_PATH_PHASE)
                chk("hall", 32'(s_tab[i]), 32'(drive.hall_code));
            if (p_tab[i] == wms_pkg::WMS_PATH_PHASE)
                chk("phase", 32'(s_tab[i]), 32'(drive.phase));
            if (p_tab[i] == wms_pkg::WMS_PATH_SPEED)
                chk("volt", slv, drive.volt_sp);
            if (m_tab[i] == `WMS_M_SPEED)
                chk("speed_sp", HALF, drive.speed_sp);
        end
        chk("stores", 32'h0, 32'(n_user + n_boot + n_erase));
        $display("test modes finished");
        apb(1'b1, `WMS_OFF_MODE, 32'h0);
        apb(1'b0, `WMS_OFF_RAMP, 32'h0);
        chk("ramp", SPEED, rd);
        apb(1'b1, `WMS_OFF_MODE, 32'h10);
        tick;
        apb(1'b0, `WMS_OFF_RAMP, 32'h0);
        chk("ramp", SPEED + HALF, rd);
        apb(1'b1, `WMS_OFF_VALUE, 32'h00040000);
        apb(1'b1, `WMS_OFF_MODE, 32'h11);
        cyc(2);
        chk("speed_sp", 32'h00020000, drive.speed_sp);
        apb(1'b1, `WMS_OFF_MODE, 32'h12);
        tick;
        apb(1'b0, `WMS_OFF_RAMP, 32'h0);
        chk("ramp", SPEED + 32'h00020000, rd);
        apb(1'b1, `WMS_OFF_VALUE, `WMS_VAL_ONE);
        apb(1'b1, `WMS_OFF_MODE, 32'h36);
        cyc(2);
        chk("gather", 32'h1, {31'h0, coast_gather});
        $display("test paths finished");
        apb(1'b1, `WMS_OFF_INERTIA, live_inertia);
        req(32'h0);
        apb(1'b1, `WMS_OFF_MODE, 32'h16);
        req(`WMS_VAL_ONE);
        chk("user", 32'h1, 32'(n_user));
        req(`WMS_VAL_TWO);
        chk("boot", 32'h1, 32'(n_boot));
        apb(1'b1, `WMS_OFF_LOCK, 32'h1);
        req(`WMS_VAL_TWO);
        chk("boot", 32'h1, 32'(n_boot));
        do_reset;
        repeat (5) tick;
        apb(1'b0, `WMS_OFF_INERTIA, 32'h0);
        chk("inertia", live_inertia, rd);
        apb(1'b1, `WMS_OFF_MODE, 32'h17);
        req(`WMS_VAL_ONE);
        chk("erase", 32'h1, 32'(n_erase));
        apb(1'b0, `WMS_OFF_INERTIA, 32'h0);
        chk("inertia", live_inertia, rd);
        do_reset;
        apb(1'b0, `WMS_OFF_INERTIA, 32'h0);
        chk("inertia", nv_boot_inertia, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test store finished");
        test_done;
    end
endmodule
`default_nettype wire
